// ==== rtl/regseq_defs.vh ====
// constants for the regulator sequencer: bus map, field layout, resets and timing
`ifndef REGSEQ_DEFS_VH
`define REGSEQ_DEFS_VH

// register byte offsets
`define RS_OFF_CTRL 12'h000
`define RS_OFF_TARGET 12'h004
`define RS_OFF_STATUS 12'h008
`define RS_OFF_IRQ_STAT 12'h00c
`define RS_OFF_IRQ_CLR 12'h010
`define RS_OFF_IRQ_EN 12'h014
`define RS_OFF_UV_MARGIN 12'h018

// control register fields
`define RS_CTRL_ZV_READY_BIT 0

// status register fields
`define RS_STAT_STATE_LSB 0
`define RS_STAT_ADDR_LSB 8
`define RS_STAT_VBOOT_BIT 12
`define RS_STAT_STRAP_BIT 13
`define RS_STAT_DAC_LSB 16

// interrupt bits
`define RS_IRQ_OCP_BIT 0
`define RS_IRQ_OVP_BIT 1
`define RS_IRQ_UVP_BIT 2
`define RS_IRQ_READY_BIT 3
`define RS_IRQ_W 4

// reset values
`define RS_CTRL_RST 1'b0
`define RS_TARGET_RST 8'h00
`define RS_UV_MARGIN_RST 8'h3c
`define RS_IRQ_EN_RST 4'h0

// boot codes of the reference dac (5 mV per step)
`define RS_VBOOT_LO_CODE 8'h97
`define RS_VBOOT_HI_CODE 8'hab

// strap ladder
`define RS_STRAP_LEVELS 18
`define RS_STRAP_MID 5'd8
`define RS_STRAP_UPPER 5'd9

// timing, printed figures in ns and the clock period
`define RS_CLK_NS 20
`define RS_OC_QUAL_NS 50000
`define RS_RDY_RISE_NS 8000
`define RS_OC_QUAL_CYC ((`RS_OC_QUAL_NS + `RS_CLK_NS - 1) / `RS_CLK_NS)
`define RS_RDY_RISE_CYC ((`RS_RDY_RISE_NS + `RS_CLK_NS - 1) / `RS_CLK_NS)
`define RS_CAL_CYC 1000
`define RS_SS_STEP_CYC 50
`define RS_OV_STEP_CYC 200

`endif

// ==== rtl/regulator_sequencer.v ====
// regulator state and fault sequencer with an ahb-lite register slave
`timescale 1ns/1ps
`include "regseq_defs.vh"

module regulator_sequencer #(
  parameter CAL_CYC = `RS_CAL_CYC,
  parameter SS_STEP_CYC = `RS_SS_STEP_CYC,
  parameter OV_STEP_CYC = `RS_OV_STEP_CYC
) (
  // clock and reset
  input wire SYS_CLK_I,
  input wire RESETN_I,
  // ahb-lite slave
  input wire HSEL_I,
  input wire [11:0] HADDR_I,
  input wire [1:0] HTRANS_I,
  input wire HWRITE_I,
  input wire [2:0] HSIZE_I,
  input wire [31:0] HWDATA_I,
  input wire HREADY_I,
  output reg [31:0] HRDATA_O,
  output reg HREADYOUT_O,
  output reg HRESP_O,
  // analog front end status
  input wire ENABLE_I,
  input wire SUPPLY_OK_I,
  input wire OV_CMP_I,
  input wire UV_CMP_I,
  input wire VOUT_LOW_I,
  input wire ILIM100_CMP_I,
  input wire ILIM150_CMP_I,
  input wire PWM_CMP_I,
  // strap measurement
  input wire STRAP_VALID_I,
  input wire [4:0] STRAP_LEVEL_I,
  output reg STRAP_ISRC_EN_O,
  // regulator controls
  output reg REGULATOR_READY_OUTPUT_O,
  output reg COMP_LOW_O,
  output reg COMP_CLAMP_O,
  output reg ERR_AMP_EN_O,
  output reg OVP_ARM_O,
  output reg UVP_ARM_O,
  output reg PHASE_ONE_MODULATION_O,
  output reg LOW_SIDE_FORCE_O,
  output reg [7:0] DAC_CODE_O,
  output reg [7:0] UV_MARGIN_O,
  // strap result
  output reg [3:0] LINK_ADDR_O,
  output reg VBOOT_HI_O,
  // interrupt
  output reg IRQ_O
);

  localparam [7:0] ST_POR = 8'h01;
  localparam [7:0] ST_DIS = 8'h02;
  localparam [7:0] ST_CAL = 8'h04;
  localparam [7:0] ST_SS = 8'h08;
  localparam [7:0] ST_RUN = 8'h10;
  localparam [7:0] ST_OV = 8'h20;
  localparam [7:0] ST_OC = 8'h40;
  localparam [7:0] ST_ZV = 8'h80;
  localparam integer OC_QUAL_N = `RS_OC_QUAL_CYC;
  localparam integer RDY_RISE_N = `RS_RDY_RISE_CYC;
  localparam integer CAL_LAST_N = CAL_CYC - 1;
  localparam integer SS_LAST_N = SS_STEP_CYC - 1;
  localparam integer OV_LAST_N = OV_STEP_CYC - 1;
  localparam [11:0] OC_QUAL = OC_QUAL_N[11:0];
  localparam [8:0] RDY_RISE = RDY_RISE_N[8:0];
  localparam [15:0] CAL_LAST = CAL_LAST_N[15:0];
  localparam [15:0] SS_LAST = SS_LAST_N[15:0];
  localparam [15:0] OV_LAST = OV_LAST_N[15:0];

  // reset release through two flops
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n = rst_sync_q;

  always @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // strap capture
  wire strap_done;
  wire [3:0] strap_addr;
  wire strap_hi;
  reg [7:0] state_q;
  reg [7:0] state_d;

  strap_capture u_strap (
    .clk(SYS_CLK_I),
    .rst_n(rst_n),
    .measure_en(state_q == ST_POR && SUPPLY_OK_I),
    .level_valid(STRAP_VALID_I),
    .level(STRAP_LEVEL_I),
    .captured_q(strap_done),
    .addr_q(strap_addr),
    .vboot_hi_q(strap_hi)
  );

  // software registers
  reg ctrl_zv_q;
  reg [7:0] target_q;
  reg target_set_q;
  reg [7:0] uv_margin_q;
  reg [3:0] irq_en_q;
  reg [3:0] irq_stat_q;
  reg [3:0] irq_stat_d;
  reg [3:0] irq_clr;

  // sequencer working state
  reg [15:0] tmr_q;
  reg [15:0] tmr_d;
  reg [11:0] oc_cnt_q;
  reg [11:0] oc_cnt_d;
  reg [8:0] rdy_cnt_q;
  reg [8:0] rdy_cnt_d;
  reg [7:0] dac_q;
  reg [7:0] dac_d;
  reg ls_force_q;
  reg ls_force_d;
  reg ev_ocp;
  reg ev_ovp;
  reg ev_uvp;
  reg ready_d;

  wire [7:0] boot_code = strap_hi ? `RS_VBOOT_HI_CODE : `RS_VBOOT_LO_CODE;
  wire [7:0] goal = target_set_q ? target_q : boot_code;
  wire zero_cmd = target_set_q && (target_q == 8'h00);
  wire switching = (state_q == ST_SS) || (state_q == ST_RUN);
  wire oc_trip = switching && (ILIM150_CMP_I || (ILIM100_CMP_I && oc_cnt_q == OC_QUAL - 12'd1));

  always @* begin
    state_d = state_q;
    tmr_d = tmr_q;
    dac_d = dac_q;
    ls_force_d = ls_force_q;
    rdy_cnt_d = 9'd0;
    oc_cnt_d = 12'd0;
    ev_ocp = 1'b0;
    ev_ovp = 1'b0;
    ev_uvp = 1'b0;
    // continuous limit assertion counts; any drop restarts timing
    if (switching && ILIM100_CMP_I && oc_cnt_q != OC_QUAL - 12'd1) begin
      oc_cnt_d = oc_cnt_q + 12'd1;
    end
    case (state_q)
      ST_POR: begin
        dac_d = 8'h00;
        if (SUPPLY_OK_I && strap_done) begin
          state_d = ST_DIS;
        end
      end
      ST_DIS: begin
        dac_d = 8'h00;
        ls_force_d = 1'b0;
        tmr_d = 16'd0;
        if (ENABLE_I) begin
          state_d = ST_CAL;
        end
      end
      ST_CAL: begin
        tmr_d = tmr_q + 16'd1;
        if (tmr_q == CAL_LAST) begin
          tmr_d = 16'd0;
          dac_d = 8'h00;
          state_d = zero_cmd ? ST_ZV : ST_SS;
        end
      end
      ST_SS: begin
        tmr_d = tmr_q + 16'd1;
        if (tmr_q == SS_LAST) begin
          tmr_d = 16'd0;
          if (dac_q < goal) begin
            dac_d = dac_q + 8'd1;
          end
        end
        if (zero_cmd) begin
          state_d = ST_ZV;
        end else if (dac_q >= goal) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        rdy_cnt_d = (rdy_cnt_q == RDY_RISE) ? rdy_cnt_q : rdy_cnt_q + 9'd1;
        tmr_d = tmr_q + 16'd1;
        if (tmr_q == SS_LAST) begin
          tmr_d = 16'd0;
          if (dac_q < goal) begin
            dac_d = dac_q + 8'd1;
          end else if (dac_q > goal) begin
            dac_d = dac_q - 8'd1;
          end
        end
        ev_uvp = UV_CMP_I;
        if (OV_CMP_I) begin
          ev_ovp = 1'b1;
          ls_force_d = 1'b1;
          tmr_d = 16'd0;
          state_d = ST_OV;
        end else if (zero_cmd) begin
          state_d = ST_ZV;
        end
      end
      ST_OV: begin
        tmr_d = tmr_q + 16'd1;
        if (tmr_q == OV_LAST) begin
          tmr_d = 16'd0;
          if (dac_q != 8'h00) begin
            dac_d = dac_q - 8'd1;
          end
        end
        if (VOUT_LOW_I) begin
          ls_force_d = 1'b0;
        end
      end
      ST_OC: begin
        dac_d = dac_q;
      end
      ST_ZV: begin
        dac_d = 8'h00;
        tmr_d = 16'd0;
        if (!zero_cmd) begin
          state_d = ST_SS;
        end
      end
      default: begin
        state_d = ST_POR;
      end
    endcase
    if (oc_trip && state_d != ST_OV) begin
      ev_ocp = 1'b1;
      state_d = ST_OC;
    end
    // loss of supply overrides every state, loss of enable every state but ST_POR; both clear latches
    if (!SUPPLY_OK_I) begin
      state_d = ST_POR;
      ls_force_d = 1'b0;
    end else if (!ENABLE_I && state_q != ST_POR) begin
      state_d = ST_DIS;
      ls_force_d = 1'b0;
    end
  end

  always @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_POR;
      tmr_q <= 16'd0;
      oc_cnt_q <= 12'd0;
      rdy_cnt_q <= 9'd0;
      dac_q <= 8'h00;
      ls_force_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      oc_cnt_q <= oc_cnt_d;
      rdy_cnt_q <= rdy_cnt_d;
      dac_q <= dac_d;
      ls_force_q <= ls_force_d;
    end
  end

  // pin outputs registered from the state, the sequencer registers, the strap result and the front end
  always @* begin
    ready_d = 1'b0;
    if (state_q == ST_RUN) begin
      ready_d = (rdy_cnt_q == RDY_RISE) && !UV_CMP_I;
    end else if (state_q == ST_ZV) begin
      ready_d = ctrl_zv_q;
    end
  end

  always @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      REGULATOR_READY_OUTPUT_O <= 1'b0;
      COMP_LOW_O <= 1'b1;
      COMP_CLAMP_O <= 1'b0;
      ERR_AMP_EN_O <= 1'b0;
      OVP_ARM_O <= 1'b0;
      UVP_ARM_O <= 1'b0;
      PHASE_ONE_MODULATION_O <= 1'b0;
      LOW_SIDE_FORCE_O <= 1'b0;
      DAC_CODE_O <= 8'h00;
      STRAP_ISRC_EN_O <= 1'b0;
      LINK_ADDR_O <= 4'h0;
      VBOOT_HI_O <= 1'b0;
    end else begin
      REGULATOR_READY_OUTPUT_O <= ready_d;
      COMP_LOW_O <= (state_q == ST_DIS) || (state_q == ST_CAL) || (state_q == ST_POR);
      COMP_CLAMP_O <= (state_q == ST_ZV);
      ERR_AMP_EN_O <= switching || (state_q == ST_OC);
      OVP_ARM_O <= switching;
      UVP_ARM_O <= switching;
      // one modulation signal, gated off outside switching states
      PHASE_ONE_MODULATION_O <= switching && PWM_CMP_I;
      LOW_SIDE_FORCE_O <= ls_force_q;
      DAC_CODE_O <= dac_q;
      STRAP_ISRC_EN_O <= (state_q == ST_POR) && SUPPLY_OK_I && !strap_done;
      LINK_ADDR_O <= strap_addr;
      VBOOT_HI_O <= strap_hi;
    end
  end

  // ahb-lite slave: one wait state, answer in the second cycle after the address phase
  reg pend_q;
  reg pend_wr_q;
  reg [11:0] pend_addr_q;
  reg [31:0] rdata;
  wire take = HSEL_I && HTRANS_I[1] && HREADY_I;
  wire wr_now = pend_q && pend_wr_q;

  always @* begin
    case (pend_addr_q)
      `RS_OFF_CTRL: rdata = {31'd0, ctrl_zv_q};
      `RS_OFF_TARGET: rdata = {24'd0, target_q};
      `RS_OFF_STATUS: rdata = {8'd0, dac_q, 2'd0, strap_done, strap_hi, strap_addr, state_q};
      `RS_OFF_IRQ_STAT: rdata = {28'd0, irq_stat_q};
      `RS_OFF_IRQ_EN: rdata = {28'd0, irq_en_q};
      `RS_OFF_UV_MARGIN: rdata = {24'd0, uv_margin_q};
      default: rdata = 32'h0000_0000;
    endcase
    irq_clr = (wr_now && pend_addr_q == `RS_OFF_IRQ_CLR) ? HWDATA_I[3:0] : 4'h0;
    // a new event wins over a clear in the same cycle
    irq_stat_d = (irq_stat_q & ~irq_clr) | {ready_d & ~REGULATOR_READY_OUTPUT_O, ev_uvp, ev_ovp, ev_ocp};
  end

  always @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      pend_wr_q <= 1'b0;
      pend_addr_q <= 12'h000;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      HRDATA_O <= 32'h0000_0000;
      ctrl_zv_q <= `RS_CTRL_RST;
      target_q <= `RS_TARGET_RST;
      target_set_q <= 1'b0;
      uv_margin_q <= `RS_UV_MARGIN_RST;
      irq_en_q <= `RS_IRQ_EN_RST;
      irq_stat_q <= 4'h0;
      UV_MARGIN_O <= `RS_UV_MARGIN_RST;
      IRQ_O <= 1'b0;
    end else begin
      pend_q <= take;
      HREADYOUT_O <= !take;
      if (take) begin
        pend_wr_q <= HWRITE_I;
        pend_addr_q <= {HADDR_I[11:2], 2'b00};
      end
      if (pend_q && !pend_wr_q) begin
        HRDATA_O <= rdata;
      end
      if (wr_now) begin
        case (pend_addr_q)
          `RS_OFF_CTRL: ctrl_zv_q <= HWDATA_I[`RS_CTRL_ZV_READY_BIT];
          `RS_OFF_TARGET: begin
            target_q <= HWDATA_I[7:0];
            target_set_q <= 1'b1;
          end
          `RS_OFF_IRQ_EN: irq_en_q <= HWDATA_I[3:0];
          `RS_OFF_UV_MARGIN: uv_margin_q <= HWDATA_I[7:0];
          default: begin
          end
        endcase
      end
      irq_stat_q <= irq_stat_d;
      UV_MARGIN_O <= uv_margin_q;
      IRQ_O <= |(irq_stat_d & irq_en_q);
    end
  end

endmodule

// ==== rtl/strap_capture.v ====
// strap level decode into link address and boot voltage, captured once
`timescale 1ns/1ps
`include "regseq_defs.vh"

module strap_capture (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // measurement
  input wire measure_en,
  input wire level_valid,
  input wire [4:0] level,
  // decoded result
  output reg captured_q,
  output reg [3:0] addr_q,
  output reg vboot_hi_q
);

  reg [4:0] lvl;
  reg [4:0] upper_off;
  reg [3:0] addr_d;
  reg vboot_hi_d;

  always @* begin
    lvl = level;
    if (level > `RS_STRAP_LEVELS - 1) begin
      lvl = 5'd17;
    end
    upper_off = lvl - `RS_STRAP_UPPER;
    // lowest eight at the low boot voltage, the rest at the high one
    if (lvl < `RS_STRAP_MID) begin
      addr_d = lvl[3:0];
      vboot_hi_d = 1'b0;
    end else if (lvl == `RS_STRAP_MID) begin
      addr_d = 4'h8;
      vboot_hi_d = 1'b1;
    end else begin
      addr_d = upper_off[3:0];
      vboot_hi_d = 1'b1;
    end
  end

  // taken once per power-up; later strap changes are ignored
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      captured_q <= 1'b0;
      addr_q <= 4'h0;
      vboot_hi_q <= 1'b0;
    end else if (measure_en && level_valid && !captured_q) begin
      captured_q <= 1'b1;
      addr_q <= addr_d;
      vboot_hi_q <= vboot_hi_d;
    end
  end

endmodule

// ==== test/regseq_asserts.sv ====
// concurrent checks on the regulator sequencer ports
`timescale 1ns/1ps
module regseq_asserts (
  // clock and reset
  input wire SYS_CLK_I,
  input wire RESETN_I,
  // bus
  input wire HSEL_I,
  input wire [1:0] HTRANS_I,
  input wire HREADY_I,
  input wire HREADYOUT_O,
  // front end
  input wire ENABLE_I,
  input wire ILIM100_CMP_I,
  input wire ILIM150_CMP_I,
  // controls
  input wire STRAP_ISRC_EN_O,
  input wire REGULATOR_READY_OUTPUT_O,
  input wire COMP_LOW_O,
  input wire COMP_CLAMP_O,
  input wire ERR_AMP_EN_O,
  input wire OVP_ARM_O,
  input wire UVP_ARM_O,
  input wire PHASE_ONE_MODULATION_O,
  input wire LOW_SIDE_FORCE_O,
  input wire [3:0] LINK_ADDR_O,
  input wire VBOOT_HI_O
);
  reg [11:0] ilim_cnt_q;
  reg isrc_q;
  reg fell_q;
  reg done_q;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // consecutive cycles of the 100% limit, and strap capture finished
  always @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ilim_cnt_q <= 12'h000;
      isrc_q <= 1'b0;
      fell_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      ilim_cnt_q <= !ILIM100_CMP_I ? 12'h000 : ilim_cnt_q + {11'h000, ilim_cnt_q != 12'hfff};
      isrc_q <= STRAP_ISRC_EN_O;
      fell_q <= isrc_q && !STRAP_ISRC_EN_O;
      done_q <= done_q || fell_q;
    end
  end
  AST_DIS_OUTS: assert property ((done_q && !ENABLE_I) [*2] |=>
    !REGULATOR_READY_OUTPUT_O && !OVP_ARM_O && !UVP_ARM_O && COMP_LOW_O) else $error("disabled outputs wrong");
  AST_READY_ARMED: assert property (REGULATOR_READY_OUTPUT_O && !COMP_CLAMP_O |->
    OVP_ARM_O && UVP_ARM_O && ERR_AMP_EN_O && !COMP_LOW_O) else $error("ready without arming");
  AST_CLAMP_DISARM: assert property (COMP_CLAMP_O |-> !OVP_ARM_O && !UVP_ARM_O) else $error("clamp armed");
  AST_OC_FAST: assert property (ILIM150_CMP_I |-> ##2 !REGULATOR_READY_OUTPUT_O &&
    !PHASE_ONE_MODULATION_O) else $error("fast limit no trip");
  AST_OC_QUAL: assert property (ilim_cnt_q == 12'd2502 |-> !REGULATOR_READY_OUTPUT_O &&
    !PHASE_ONE_MODULATION_O) else $error("limit qualify no trip");
  AST_BUS_WAIT: assert property (HSEL_I && HTRANS_I[1] && HREADY_I |=> !HREADYOUT_O ##1 HREADYOUT_O)
    else $error("bus wait state wrong");
  AST_STRAP_HOLD: assert property (done_q |-> $stable(LINK_ADDR_O) && $stable(VBOOT_HI_O))
    else $error("strap result changed");
  AST_OV_FORCE: assert property (LOW_SIDE_FORCE_O |-> !PHASE_ONE_MODULATION_O &&
    !REGULATOR_READY_OUTPUT_O) else $error("low side force with switching");
  COV_OV: cover property (LOW_SIDE_FORCE_O);
  COV_ZV: cover property (COMP_CLAMP_O && REGULATOR_READY_OUTPUT_O);
  COV_OC: cover property (ILIM100_CMP_I && $fell(REGULATOR_READY_OUTPUT_O));
endmodule
bind regulator_sequencer regseq_asserts u_regseq_asserts (
  .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I), .HREADY_I(HREADY_I),
  .HREADYOUT_O(HREADYOUT_O), .ENABLE_I(ENABLE_I), .ILIM100_CMP_I(ILIM100_CMP_I), .ILIM150_CMP_I(ILIM150_CMP_I),
  .STRAP_ISRC_EN_O(STRAP_ISRC_EN_O), .REGULATOR_READY_OUTPUT_O(REGULATOR_READY_OUTPUT_O),
  .COMP_LOW_O(COMP_LOW_O), .COMP_CLAMP_O(COMP_CLAMP_O), .ERR_AMP_EN_O(ERR_AMP_EN_O), .OVP_ARM_O(OVP_ARM_O),
  .UVP_ARM_O(UVP_ARM_O), .PHASE_ONE_MODULATION_O(PHASE_ONE_MODULATION_O), .LOW_SIDE_FORCE_O(LOW_SIDE_FORCE_O),
  .LINK_ADDR_O(LINK_ADDR_O), .VBOOT_HI_O(VBOOT_HI_O));

// ==== test/strap_ladder_model.sv ====
// strap ladder model answering the strap current source
`timescale 1ns/1ps
module strap_ladder_model (
  // clock
  input wire clk_i,
  // strap measurement
  input wire isrc_en_i,
  input wire [4:0] level_cfg_i,
  output reg valid_o,
  output reg [4:0] level_o
);
  reg [2:0] settle_q;
  initial begin
    valid_o = 1'b0;
    level_o = 5'h00;
    settle_q = 3'h0;
  end
  // level settles a few cycles after the source turns on, garbage otherwise
  always @(posedge clk_i) begin
    if (isrc_en_i) begin
      settle_q <= settle_q + {2'h0, settle_q != 3'h7};
      valid_o <= settle_q > 3'h3;
      level_o <= settle_q > 3'h3 ? level_cfg_i : ~level_o;
    end else begin
      settle_q <= 3'h0;
      valid_o <= 1'b0;
      level_o <= ~level_o;
    end
  end
endmodule

// ==== test/tb.sv ====
// self-checking bench for the regulator sequencer
`timescale 1ns/1ps
`include "regseq_defs.vh"
module tb;
  reg SYS_CLK_I = 0, RESETN_I = 0, HSEL_I = 0, HWRITE_I = 0, ENABLE_I = 0, SUPPLY_OK_I = 1, rd_act = 0;
  reg OV_CMP_I = 0, UV_CMP_I = 0, VOUT_LOW_I = 0, ILIM100_CMP_I = 0, ILIM150_CMP_I = 0, PWM_CMP_I = 0;
  reg [11:0] HADDR_I = 0;
  reg [1:0] HTRANS_I = 0;
  reg [31:0] HWDATA_I = 0;
  reg [4:0] strap_cfg = 0;
  reg [3:0] ea;
  reg ev;
  reg [7:0] boot, m;
  wire [31:0] HRDATA_O;
  wire [7:0] DAC_CODE_O, UV_MARGIN_O;
  wire [4:0] STRAP_LEVEL_I;
  wire [3:0] LINK_ADDR_O;
  wire HREADYOUT_O, HRESP_O, STRAP_VALID_I, STRAP_ISRC_EN_O, REGULATOR_READY_OUTPUT_O, COMP_LOW_O, COMP_CLAMP_O;
  wire ERR_AMP_EN_O, OVP_ARM_O, UVP_ARM_O, PHASE_ONE_MODULATION_O, LOW_SIDE_FORCE_O, VBOOT_HI_O, IRQ_O;
  wire HREADY_I = HREADYOUT_O;
  wire [2:0] HSIZE_I = 3'h2;
  integer bad_count = 0, checks = 0, seed = 32'hf4f8dea9, i, k, lvl;
  logic [31:0] exp_q[$];
  regulator_sequencer #(.CAL_CYC(4), .SS_STEP_CYC(2), .OV_STEP_CYC(2)) u_regulator_sequencer (
    .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
    .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .ENABLE_I(ENABLE_I), .SUPPLY_OK_I(SUPPLY_OK_I),
    .OV_CMP_I(OV_CMP_I), .UV_CMP_I(UV_CMP_I), .VOUT_LOW_I(VOUT_LOW_I), .ILIM100_CMP_I(ILIM100_CMP_I),
    .ILIM150_CMP_I(ILIM150_CMP_I), .PWM_CMP_I(PWM_CMP_I), .STRAP_VALID_I(STRAP_VALID_I),
    .STRAP_LEVEL_I(STRAP_LEVEL_I), .STRAP_ISRC_EN_O(STRAP_ISRC_EN_O),
    .REGULATOR_READY_OUTPUT_O(REGULATOR_READY_OUTPUT_O), .COMP_LOW_O(COMP_LOW_O), .COMP_CLAMP_O(COMP_CLAMP_O),
    .ERR_AMP_EN_O(ERR_AMP_EN_O), .OVP_ARM_O(OVP_ARM_O), .UVP_ARM_O(UVP_ARM_O),
    .PHASE_ONE_MODULATION_O(PHASE_ONE_MODULATION_O), .LOW_SIDE_FORCE_O(LOW_SIDE_FORCE_O),
    .DAC_CODE_O(DAC_CODE_O), .UV_MARGIN_O(UV_MARGIN_O), .LINK_ADDR_O(LINK_ADDR_O), .VBOOT_HI_O(VBOOT_HI_O),
    .IRQ_O(IRQ_O));
  strap_ladder_model u_strap_ladder_model (.clk_i(SYS_CLK_I), .isrc_en_i(STRAP_ISRC_EN_O),
    .level_cfg_i(strap_cfg), .valid_o(STRAP_VALID_I), .level_o(STRAP_LEVEL_I));
  always #10 SYS_CLK_I = ~SYS_CLK_I;
  task final_report;
    begin
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [31:0] e, input [31:0] g, input [8*8:1] nm);
    begin
      checks = checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task w(input integer n);
    repeat (n) @(negedge SYS_CLK_I);
  endtask
  task bus(input wr, input [11:0] a, input [31:0] d);
    begin
      @(posedge SYS_CLK_I);
      HSEL_I <= 1'b1;
      HTRANS_I <= 2'h2;
      HWRITE_I <= wr;
      HADDR_I <= a;
      @(posedge SYS_CLK_I);
      while (HREADYOUT_O !== 1'b1) @(posedge SYS_CLK_I);
      HSEL_I <= 1'b0;
      HTRANS_I <= 2'h0;
      HWDATA_I <= d;
      rd_act <= !wr;
      @(posedge SYS_CLK_I);
      while (HREADYOUT_O !== 1'b1) @(posedge SYS_CLK_I);
      rd_act <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] e);
    begin
      exp_q.push_back(e);
      bus(1'b0, a, $random(seed));
    end
  endtask
  always @(posedge SYS_CLK_I) begin
    if (rd_act && HREADYOUT_O) begin
      chk(exp_q.pop_front(), HRDATA_O, "hrdata");
      chk(0, HRESP_O, "hresp");
    end
  end
  task go;
    begin
      @(posedge SYS_CLK_I) ENABLE_I <= 1'b1;
      k = 0;
      while (REGULATOR_READY_OUTPUT_O !== 1'b1 && k < 3000) begin
        @(posedge SYS_CLK_I);
        k = k + 1;
      end
      w(1);
      chk(1, REGULATOR_READY_OUTPUT_O, "ready");
    end
  endtask
  task off;
    begin
      @(posedge SYS_CLK_I) ENABLE_I <= 1'b0;
      w(4);
      chk(0, REGULATOR_READY_OUTPUT_O, "ready");
      chk(0, OVP_ARM_O, "ovparm");
      chk(0, UVP_ARM_O, "uvparm");
      chk(1, COMP_LOW_O, "complow");
    end
  endtask
  initial begin
    #1000000;
    bad_count = bad_count + 1;
    final_report;
  end
  initial begin
    lvl = $unsigned($random(seed)) % 18;
    strap_cfg = lvl;
    ea = lvl < 9 ? lvl : lvl - 9;
    ev = lvl > 7;
    boot = ev ? `RS_VBOOT_HI_CODE : `RS_VBOOT_LO_CODE;
    repeat (2) @(posedge SYS_CLK_I);
    RESETN_I <= 1'b1;
    w(24);
    strap_cfg <= lvl ^ 5'h1;
    chk(ea, LINK_ADDR_O, "addr");
    chk(ev, VBOOT_HI_O, "vboot");
    rd(`RS_OFF_UV_MARGIN, `RS_UV_MARGIN_RST);
    rd(12'h1fc, 0);
    @(posedge SYS_CLK_I) ENABLE_I <= 1'b1;
    w(30);
    chk(0, REGULATOR_READY_OUTPUT_O, "ready");
    chk(1, ERR_AMP_EN_O, "erramp");
    @(posedge SYS_CLK_I) OV_CMP_I <= 1'b1;
    w(3);
    @(posedge SYS_CLK_I) OV_CMP_I <= 1'b0;
    go;
    chk(boot, DAC_CODE_O, "dac");
    rd(`RS_OFF_STATUS, {8'h00, boot, 2'b00, 1'b1, ev, ea, 8'h10});
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge SYS_CLK_I) PWM_CMP_I <= $random(seed);
      w(3);
      chk(PWM_CMP_I, PHASE_ONE_MODULATION_O, "pwm");
    end
    @(posedge SYS_CLK_I) PWM_CMP_I <= 1'b1;
    m = $random(seed);
    bus(1'b1, `RS_OFF_UV_MARGIN, {24'h0, m});
    w(2);
    chk(m, UV_MARGIN_O, "margin");
    bus(1'b1, `RS_OFF_IRQ_EN, 32'h4);
    @(posedge SYS_CLK_I) UV_CMP_I <= 1'b1;
    w(3);
    chk(0, REGULATOR_READY_OUTPUT_O, "ready");
    chk(1, IRQ_O, "irq");
    bus(1'b1, `RS_OFF_IRQ_EN, 32'h0);
    bus(1'b1, `RS_OFF_IRQ_CLR, 32'hf);
    rd(`RS_OFF_IRQ_STAT, 32'h4);
    chk(0, IRQ_O, "irq");
    @(posedge SYS_CLK_I) UV_CMP_I <= 1'b0;
    w(3);
    bus(1'b1, `RS_OFF_IRQ_CLR, 32'hf);
    rd(`RS_OFF_IRQ_STAT, 32'h0);
    go;
    @(posedge SYS_CLK_I) ILIM100_CMP_I <= 1'b1;
    w(2000);
    @(posedge SYS_CLK_I) ILIM100_CMP_I <= 1'b0;
    @(posedge SYS_CLK_I) ILIM100_CMP_I <= 1'b1;
    w(2501);
    chk(1, REGULATOR_READY_OUTPUT_O, "ready");
    w(1);
    chk(0, REGULATOR_READY_OUTPUT_O, "ready");
    chk(0, PHASE_ONE_MODULATION_O, "pwm");
    @(posedge SYS_CLK_I) ILIM100_CMP_I <= 1'b0;
    w(600);
    chk(0, REGULATOR_READY_OUTPUT_O, "ready");
    rd(`RS_OFF_STATUS, {8'h00, boot, 2'b00, 1'b1, ev, ea, 8'h40});
    rd(`RS_OFF_IRQ_STAT, 32'h1);
    off;
    go;
    @(posedge SYS_CLK_I) ILIM150_CMP_I <= 1'b1;
    w(3);
    chk(0, REGULATOR_READY_OUTPUT_O, "ready");
    @(posedge SYS_CLK_I) ILIM150_CMP_I <= 1'b0;
    off;
    go;
    @(posedge SYS_CLK_I) OV_CMP_I <= 1'b1;
    w(4);
    chk(1, LOW_SIDE_FORCE_O, "lowside");
    @(posedge SYS_CLK_I) OV_CMP_I <= 1'b0;
    w(20);
    chk(1, DAC_CODE_O < boot, "dacdown");
    @(posedge SYS_CLK_I) VOUT_LOW_I <= 1'b1;
    w(3);
    chk(0, LOW_SIDE_FORCE_O, "lowside");
    chk(0, REGULATOR_READY_OUTPUT_O, "ready");
    @(posedge SYS_CLK_I) VOUT_LOW_I <= 1'b0;
    off;
    go;
    @(posedge SYS_CLK_I) SUPPLY_OK_I <= 1'b0;
    w(4);
    chk(0, REGULATOR_READY_OUTPUT_O, "ready");
    @(posedge SYS_CLK_I) SUPPLY_OK_I <= 1'b1;
    go;
    bus(1'b1, `RS_OFF_TARGET, 32'h0);
    w(5);
    chk(1, COMP_CLAMP_O, "clamp");
    chk(0, REGULATOR_READY_OUTPUT_O, "ready");
    bus(1'b1, `RS_OFF_CTRL, 32'h1);
    w(3);
    chk(1, REGULATOR_READY_OUTPUT_O, "ready");
    final_report;
  end
endmodule
